// ### rtl/kb_link_defs.svh
// Purpose: constants for the keyboard serial link device
// Assumes: included by bare name before the package and the modules
// Notes: times kept in their own units, cycle counts derived in the module
// Summary of operation
// RULE1: Idle link: clock floats high, keyboard leaves data high; both lines open drain.
// RULE2: Host pulling clock low inhibits keyboard transmission.
// RULE3: Keyboard drives the clock itself while sending a byte.
// RULE4: Frame is start 0, eight data bits LSB first, odd parity, stop 1.
// RULE5: Clock low before sending keeps the pending byte queued.
// RULE6: Data low with clock high is a host request; keyboard receives instead.
// RULE7: Transmission starts only with both clock and data high.
// RULE8: Clock pulled low before parity aborts, requeues and releases; later frames finish.
// RULE9: Lines stay released during the power-on self-test.
// RULE10: Reset command acks, waits for a long high pulse, then self-tests.
// RULE11: Resend repeats last output, skipping a resend request of its own.
// RULE12: Set-default acks, restores rate and delay, keeps scan enable.
// RULE13: Default-disable is set-default but stops scanning.
// RULE14: Enable acks, flushes output buffer and typematic key, starts scanning.
// RULE15: Rate parameter: bit7 zero, delay bits 6:5, delay is (field+1)*250 ms.
// RULE16: Repeat period is (8+A)*2^B units, 30.0 down to 2.0 per second.
// RULE17: Rate command awaits parameter; a new command replaces it and scanning stays off.
// RULE18: Read-ID acks, stops scanning, sends two identification bytes.
// RULE19: Scan-set command flushes, takes option 01, 02 or 00, acks and reports set.
// RULE20: Command replacing scan-set option keeps current set; flush already done.
// RULE21: Echo command is answered with the echo byte; scanning continues.
// RULE22: Indicator option: bit0 scroll, bit1 numeric, any combination.
// RULE23: Every valid input except echo and resend gets an ack; aborted ack is dropped.
// RULE24: Invalid byte or bad parity is answered with a resend request.
// RULE25: Indicator command acks twice; a replacing command leaves indicators alone.
// RULE26: Host samples keyboard bits on falling clock and checks start, parity, stop.
`ifndef KB_LINK_DEFS_SVH
`define KB_LINK_DEFS_SVH
`define KB_CLK_NS 4
`define KB_TX_HALF_NS 40000
`define KB_RST_PULSE_MS 500
`define KB_DELAY_UNIT_MS 250
`define KB_BYTE_ACK 8'hFA
`define KB_BYTE_NAK 8'hFE
`define KB_BYTE_ECHO 8'hEE
`define KB_BYTE_ST_PASS 8'hAA
`define KB_BYTE_ST_FAIL 8'hFC
`define KB_CMD_RESET 8'hFF
`define KB_CMD_RESEND 8'hFE
`define KB_CMD_DEFAULTS 8'hF6
`define KB_CMD_DEF_DISABLE 8'hF5
`define KB_CMD_ENABLE 8'hF4
`define KB_CMD_RATE 8'hF3
`define KB_CMD_READ_ID 8'hF2
`define KB_CMD_SCAN_SET 8'hF0
`define KB_CMD_ECHO 8'hEE
`define KB_CMD_LEDS 8'hED
`define KB_SET_QUERY 8'h00
`define KB_SET_ONE 8'h01
`define KB_SET_TWO 8'h02
`define KB_DEF_RATE 5'h0B
`define KB_DEF_DELAY 2'h1
`define KB_OFF_CTRL 4'h0
`define KB_OFF_STATUS 4'h4
`define KB_OFF_KEY 4'h8
`define KB_OFF_TYPEM 4'hC
`define KB_CTRL_PASS 0
`define KB_CTRL_FAIL 1
`define KB_STS_SELFTEST 0
`define KB_STS_SCAN_EN 1
`define KB_STS_SCAN_ACT 2
`define KB_STS_RST_MODE 3
`define KB_STS_WAIT_PARAM 4
`define KB_STS_KEY_PEND 5
`define KB_STS_SET2 6
`define KB_STS_LED_LSB 8
`define KB_TYP_MS_LSB 8
`define KB_TYP_PER_LSB 24
`endif

// ### rtl/kb_link_pkg.sv
// Purpose: types shared by the keyboard link device
// Assumes: nothing
// Notes: state codes left to the tools
package kb_link_pkg;
	typedef enum {LINK_IDLE, LINK_TX, LINK_RX} link_state_type;
	typedef enum {CMD_IDLE, CMD_WAIT_RATE, CMD_WAIT_SET, CMD_WAIT_LED} cmd_state_type;
endpackage

// ### rtl/kb_sync2.sv
// Purpose: two-flop synchroniser for the link pins
// Assumes: inputs asynchronous to i_clk
// Notes: first stage feeds only the second
`timescale 1ns/1ns
module kb_sync2 #(
	parameter int unsigned WIDTH = 2
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta;

	// Idle lines float high, so reset to high
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			meta <= '1;
			o_sync <= '1;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule

// ### rtl/kb_link_device.sv
// Purpose: keyboard side of the two-wire link with inbound command handler
// Assumes: TX_HALF_CYCLES above 4; host clocks inbound frames itself
// Notes: one pending key byte slot, fed over Avalon-MM
`timescale 1ns/1ns
`include "kb_link_defs.svh"
module kb_link_device
	import kb_link_pkg::*;
#(
	parameter int unsigned TX_HALF_CYCLES = `KB_TX_HALF_NS / `KB_CLK_NS,
	parameter int unsigned RST_PULSE_CYCLES = `KB_RST_PULSE_MS * 1000000 / `KB_CLK_NS,
	// Identification bytes: values arbitrary
	parameter logic [7:0] ID_FIRST = 8'h5A,
	parameter logic [7:0] ID_SECOND = 8'h3C
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_kbd_clk,
	output logic o_kbd_clk_out,
	output logic o_kbd_clk_oe,
	input wire logic i_kbd_data,
	output logic o_kbd_data_out,
	output logic o_kbd_data_oe,
	output logic o_scan_active,
	output logic o_flush,
	output logic [2:0] o_leds,
	output logic o_scan_set2,
	output logic [9:0] o_typematic_delay_ms,
	output logic [7:0] o_typematic_period
);
	localparam logic [15:0] HALF_M1 = 16'(TX_HALF_CYCLES - 1);
	localparam logic [27:0] RST_M1 = 28'(RST_PULSE_CYCLES - 1);

	wire [1:0] line_s;
	wire clk_s = line_s[1];
	wire dat_s = line_s[0];
	logic clk_d;

	link_state_type link_st;
	logic [3:0] bit_idx;
	logic tx_phase;
	logic [15:0] hc;
	logic [7:0] tx_byte;
	logic tx_from_resp;
	logic [10:0] rx_sh;
	logic tx_done;
	logic tx_abort;
	logic rx_done;

	cmd_state_type cmd_st;
	logic [7:0] resp [0:2];
	logic [1:0] resp_cnt;
	logic [7:0] last_tx;
	logic [7:0] key_byte;
	logic key_valid;
	logic scan_en;
	logic st_run;
	logic reset_mode;
	logic [27:0] rst_cnt;
	logic id_hold;
	logic [4:0] rate;
	logic [1:0] delay;
	logic rd_ready;
	logic set2_q;
	logic tx_phase_d;

	kb_sync2 #(
		.WIDTH(2)
	) u_sync (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_async({i_kbd_clk, i_kbd_data}),
		.o_sync(line_s)
	);

	wire fall = clk_d & ~clk_s;
	// RULE4 frame layout
	wire [10:0] tx_frame = {1'b1, ~^tx_byte, tx_byte, 1'b0};
	wire [7:0] rx_byte = rx_sh[8:1];
	wire rx_ok = ~rx_sh[0] & rx_sh[10] & (^rx_sh[9:1]);
	wire have_resp = resp_cnt != 2'd0;
	wire scan_act = scan_en && cmd_st == CMD_IDLE && !id_hold && !st_run && !reset_mode;
	wire tx_req = have_resp || (key_valid && scan_act);
	wire [7:0] tx_src = have_resp ? resp[0] : key_byte;
	// RULE2 RULE5 clock held low keeps the byte queued
	wire tx_start = link_st == LINK_IDLE && tx_req && clk_s && dat_s && hc == HALF_M1
		&& !st_run;
	wire valid_cmd = rx_byte == `KB_CMD_LEDS || rx_byte == `KB_CMD_ECHO
		|| rx_byte == `KB_CMD_SCAN_SET || rx_byte >= `KB_CMD_READ_ID;
	wire rx_new = rx_done && !st_run;

	// RULE1 open drain: only ever pull low
	assign o_kbd_clk_out = 1'b0;
	assign o_kbd_data_out = 1'b0;
	// RULE3 keyboard times its own bits
	assign o_kbd_clk_oe = link_st == LINK_TX && tx_phase;
	assign o_kbd_data_oe = link_st == LINK_TX && !tx_frame[bit_idx];
	assign o_scan_active = scan_act;
	assign o_scan_set2 = set2_q;
	// RULE15 delay in milliseconds
	assign o_typematic_delay_ms = 10'((11'(delay) + 11'd1) * 11'(`KB_DELAY_UNIT_MS));
	// RULE16 period in units of 8.34/2 ms
	assign o_typematic_period = 8'(4'd8 + 4'(rate[2:0])) << rate[4:3];

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			link_st <= LINK_IDLE;
			clk_d <= 1'b1;
			bit_idx <= 4'h0;
			tx_phase <= 1'b0;
			hc <= 16'h0000;
			tx_byte <= 8'h00;
			tx_from_resp <= 1'b0;
			rx_sh <= 11'h000;
			tx_done <= 1'b0;
			tx_abort <= 1'b0;
			rx_done <= 1'b0;
		end else begin
			clk_d <= clk_s;
			tx_done <= 1'b0;
			tx_abort <= 1'b0;
			rx_done <= 1'b0;
			unique case (link_st)
				LINK_IDLE: begin
					bit_idx <= 4'h0;
					tx_phase <= 1'b0;
					// Both lines must stay high for a half bit before we talk
					if (!(clk_s && dat_s)) begin
						hc <= 16'h0000;
					end else if (hc != HALF_M1) begin
						hc <= hc + 16'h0001;
					end
					// RULE9 self-test ignores and leaves the lines
					if (st_run) begin
						hc <= 16'h0000;
					// RULE6 host request to send wins over our pending byte
					end else if (clk_s && !dat_s) begin
						link_st <= LINK_RX;
						hc <= 16'h0000;
					// RULE7 start only with both lines high
					end else if (tx_start) begin
						link_st <= LINK_TX;
						tx_byte <= tx_src;
						tx_from_resp <= have_resp;
						hc <= 16'h0000;
					end
				end
				LINK_TX: begin
					hc <= hc + 16'h0001;
					// RULE8 watch clock while released; skip sync lag after release
					if (!tx_phase && hc > 16'h0003 && !clk_s && bit_idx <= 4'h9) begin
						link_st <= LINK_IDLE;
						tx_abort <= 1'b1;
						hc <= 16'h0000;
					end else if (hc == HALF_M1) begin
						hc <= 16'h0000;
						tx_phase <= !tx_phase;
						if (tx_phase) begin
							if (bit_idx == 4'hA) begin
								link_st <= LINK_IDLE;
								tx_done <= 1'b1;
							end else begin
								bit_idx <= bit_idx + 4'h1;
							end
						end
					end
				end
				LINK_RX: begin
					hc <= hc + 16'h0001;
					if (fall) begin
						hc <= 16'h0000;
						rx_sh[bit_idx] <= dat_s;
						if (bit_idx == 4'hA) begin
							link_st <= LINK_IDLE;
							rx_done <= 1'b1;
						end else begin
							bit_idx <= bit_idx + 4'h1;
						end
					end else if (hc == HALF_M1) begin
						// Host stopped clocking: drop the partial frame
						link_st <= LINK_IDLE;
						hc <= 16'h0000;
					end
				end
			endcase
		end
	end

	wire acc = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
	wire key_wr = acc && i_avs_address == `KB_OFF_KEY;
	wire ctrl_wr = acc && i_avs_address == `KB_OFF_CTRL;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cmd_st <= CMD_IDLE;
			resp[0] <= 8'h00;
			resp[1] <= 8'h00;
			resp[2] <= 8'h00;
			resp_cnt <= 2'd0;
			last_tx <= 8'h00;
			key_byte <= 8'h00;
			key_valid <= 1'b0;
			scan_en <= 1'b0;
			st_run <= 1'b1;
			reset_mode <= 1'b0;
			rst_cnt <= 28'h000_0000;
			id_hold <= 1'b0;
			rate <= `KB_DEF_RATE;
			delay <= `KB_DEF_DELAY;
			o_leds <= 3'h0;
			set2_q <= 1'b0;
			o_flush <= 1'b0;
		end else begin
			o_flush <= 1'b0;
			// RULE23 an interrupted ack is not retried
			if ((tx_done || (tx_abort && tx_byte == `KB_BYTE_ACK)) && tx_from_resp) begin
				resp[0] <= resp[1];
				resp[1] <= resp[2];
				resp_cnt <= resp_cnt - 2'd1;
			end
			// RULE5 key byte leaves the slot once fully sent or when flushed; an abort keeps it
			if (tx_done && !tx_from_resp) begin
				key_valid <= 1'b0;
			end
			// RULE11 never remember our own resend request
			if (tx_done && tx_byte != `KB_BYTE_NAK) begin
				last_tx <= tx_byte;
			end
			// RULE18 scanning resumes once both ID bytes are out
			if (id_hold && !have_resp && link_st != LINK_TX) begin
				id_hold <= 1'b0;
			end
			if (key_wr) begin
				key_byte <= i_avs_writedata[7:0];
				key_valid <= 1'b1;
			end
			if (ctrl_wr && st_run
				&& (i_avs_writedata[`KB_CTRL_PASS] || i_avs_writedata[`KB_CTRL_FAIL])) begin
				st_run <= 1'b0;
				scan_en <= !i_avs_writedata[`KB_CTRL_FAIL];
				resp[0] <= i_avs_writedata[`KB_CTRL_FAIL] ? `KB_BYTE_ST_FAIL : `KB_BYTE_ST_PASS;
				resp_cnt <= 2'd1;
			end
			// RULE10 wait for the ack to go, then a long high pulse
			if (reset_mode && !have_resp && link_st == LINK_IDLE) begin
				if (!(clk_s && dat_s)) begin
					rst_cnt <= 28'h000_0000;
				end else if (rst_cnt == RST_M1) begin
					reset_mode <= 1'b0;
					st_run <= 1'b1;
					scan_en <= 1'b0;
					rate <= `KB_DEF_RATE;
					delay <= `KB_DEF_DELAY;
					o_leds <= 3'h0;
					set2_q <= 1'b0;
					key_valid <= 1'b0;
				end else begin
					rst_cnt <= rst_cnt + 28'h000_0001;
				end
			end
			if (rx_new) begin
				resp[0] <= `KB_BYTE_ACK;
				resp_cnt <= 2'd1;
				// RULE24 bad parity or framing
				if (!rx_ok) begin
					resp[0] <= `KB_BYTE_NAK;
				// RULE15 parameter accepted
				end else if (cmd_st == CMD_WAIT_RATE && !rx_byte[7]) begin
					delay <= rx_byte[6:5];
					rate <= rx_byte[4:0];
					cmd_st <= CMD_IDLE;
				// RULE19 option 00 queries, 01 and 02 select
				end else if (cmd_st == CMD_WAIT_SET && rx_byte <= `KB_SET_TWO) begin
					if (rx_byte != `KB_SET_QUERY) begin
						set2_q <= rx_byte == `KB_SET_TWO;
					end
					resp[1] <= (rx_byte == `KB_SET_QUERY ? set2_q : rx_byte == `KB_SET_TWO)
						? `KB_SET_TWO : `KB_SET_ONE;
					resp_cnt <= 2'd2;
					cmd_st <= CMD_IDLE;
				// RULE22 bit0 scroll, bit1 numeric, bit2 caps
				end else if (cmd_st == CMD_WAIT_LED && rx_byte[7:3] == 5'h00) begin
					o_leds <= rx_byte[2:0];
					cmd_st <= CMD_IDLE;
				end else if (valid_cmd) begin
					// RULE20 a replaced parameter leaves settings alone
					cmd_st <= CMD_IDLE;
					reset_mode <= 1'b0;
					// RULE17 replaced rate command leaves scanning off
					if (cmd_st == CMD_WAIT_RATE) begin
						scan_en <= 1'b0;
					end
					case (rx_byte)
						`KB_CMD_RESET: begin
							reset_mode <= 1'b1;
							rst_cnt <= 28'h000_0000;
						end
						`KB_CMD_RESEND: begin
							resp[0] <= last_tx;
						end
						// RULE12 defaults keep scan enable
						`KB_CMD_DEFAULTS: begin
							rate <= `KB_DEF_RATE;
							delay <= `KB_DEF_DELAY;
						end
						// RULE13 defaults and stop
						`KB_CMD_DEF_DISABLE: begin
							rate <= `KB_DEF_RATE;
							delay <= `KB_DEF_DELAY;
							scan_en <= 1'b0;
						end
						// RULE14 flush and enable
						`KB_CMD_ENABLE: begin
							o_flush <= 1'b1;
							key_valid <= 1'b0;
							scan_en <= 1'b1;
						end
						`KB_CMD_RATE: begin
							cmd_st <= CMD_WAIT_RATE;
						end
						// RULE18 ack then both ID bytes
						`KB_CMD_READ_ID: begin
							resp[1] <= ID_FIRST;
							resp[2] <= ID_SECOND;
							resp_cnt <= 2'd3;
							id_hold <= 1'b1;
						end
						`KB_CMD_SCAN_SET: begin
							o_flush <= 1'b1;
							key_valid <= 1'b0;
							cmd_st <= CMD_WAIT_SET;
						end
						// RULE21 echo without ack
						`KB_CMD_ECHO: begin
							resp[0] <= `KB_BYTE_ECHO;
						end
						// RULE25 ack, then wait for the option byte
						`KB_CMD_LEDS: begin
							cmd_st <= CMD_WAIT_LED;
						end
						default: begin
						end
					endcase
				end else begin
					resp[0] <= `KB_BYTE_NAK;
				end
			end
		end
	end

	// Reads take one wait cycle so read data comes from a flop
	assign o_avs_waitrequest = (i_avs_read && !rd_ready)
		|| (i_avs_write && i_avs_address == `KB_OFF_KEY && key_valid);

	logic [31:0] next_readdata;

	always_comb begin
		next_readdata = 32'h0000_0000;
		case (i_avs_address)
			`KB_OFF_CTRL: begin
				next_readdata[`KB_STS_SELFTEST] = st_run;
			end
			`KB_OFF_STATUS: begin
				next_readdata[`KB_STS_SELFTEST] = st_run;
				next_readdata[`KB_STS_SCAN_EN] = scan_en;
				next_readdata[`KB_STS_SCAN_ACT] = scan_act;
				next_readdata[`KB_STS_RST_MODE] = reset_mode;
				next_readdata[`KB_STS_WAIT_PARAM] = cmd_st != CMD_IDLE;
				next_readdata[`KB_STS_KEY_PEND] = key_valid;
				next_readdata[`KB_STS_SET2] = set2_q;
				next_readdata[`KB_STS_LED_LSB +: 3] = o_leds;
			end
			`KB_OFF_KEY: begin
				next_readdata[7:0] = key_byte;
			end
			`KB_OFF_TYPEM: begin
				next_readdata[6:0] = {delay, rate};
				next_readdata[`KB_TYP_MS_LSB +: 10] = o_typematic_delay_ms;
				next_readdata[`KB_TYP_PER_LSB +: 8] = o_typematic_period;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rd_ready <= 1'b0;
			o_avs_readdata <= 32'h0000_0000;
		end else begin
			rd_ready <= i_avs_read && !rd_ready;
			if (i_avs_read && !rd_ready) begin
				o_avs_readdata <= next_readdata;
			end
		end
	end

	logic [3:0] clk_pulls;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			clk_pulls <= 4'h0;
		end else if (tx_start) begin
			clk_pulls <= 4'h0;
		end else if (o_kbd_clk_oe && !tx_phase_d) begin
			clk_pulls <= clk_pulls + 4'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tx_phase_d <= 1'b0;
		end else begin
			tx_phase_d <= o_kbd_clk_oe;
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_cmd(logic [7:0] c);
		rx_new && rx_ok && rx_byte == c;
	endsequence

	chk_idle_released: assert property ( // RULE1
		link_st != LINK_TX |-> !o_kbd_clk_oe && !o_kbd_data_oe)
		else $error("link driven outside a frame");
	chk_start_lines_high: assert property ( // RULE7
		tx_start |-> clk_s && dat_s && !st_run)
		else $error("frame started without both lines high");
	chk_inhibit_holds: assert property ( // RULE5
		!clk_s && key_valid && link_st == LINK_IDLE && !rx_new && !tx_done |=> key_valid)
		else $error("queued byte lost while inhibited");
	chk_clock_pulses: assert property ( // RULE3
		tx_done |-> clk_pulls == 4'hB)
		else $error("frame did not carry eleven clock pulses");
	chk_frame_bits: assert property ( // RULE4
		tx_start |=> o_kbd_data_oe)
		else $error("start bit not driven low");
	chk_parity_bit: assert property ( // RULE4
		link_st == LINK_TX && bit_idx == 4'h9 |-> o_kbd_data_oe == ^tx_byte)
		else $error("parity bit wrong");
	chk_abort_release: assert property ( // RULE8
		tx_abort |-> (tx_from_resp || key_valid) ##1 (!o_kbd_clk_oe && !o_kbd_data_oe))
		else $error("abort did not requeue and release");
	chk_selftest_quiet: assert property ( // RULE9
		st_run |-> !o_kbd_clk_oe && !o_kbd_data_oe)
		else $error("lines driven during self-test");
	chk_reset_ack: assert property ( // RULE10
		s_cmd(`KB_CMD_RESET) |=> reset_mode && resp[0] == `KB_BYTE_ACK)
		else $error("reset command not acknowledged");
	chk_enable_flush: assert property ( // RULE14
		s_cmd(`KB_CMD_ENABLE) |=> o_flush && scan_en && !key_valid ##1 !o_flush)
		else $error("enable did not flush and start scanning");
	chk_rate_apply: assert property ( // RULE15
		rx_new && rx_ok && cmd_st == CMD_WAIT_RATE && !rx_byte[7]
		|=> o_typematic_delay_ms == 10'((11'(rx_byte[6:5]) + 11'd1) * 11'd250))
		else $error("typematic delay not applied");
	chk_echo_reply: assert property ( // RULE21
		s_cmd(`KB_CMD_ECHO) |=> resp_cnt == 2'd1 && resp[0] == `KB_BYTE_ECHO)
		else $error("echo not answered");
	chk_bad_parity_nak: assert property ( // RULE24
		rx_new && !rx_ok |=> resp_cnt == 2'd1 && resp[0] == `KB_BYTE_NAK)
		else $error("bad frame not answered with resend");
endmodule

// ### test/kb_host_model.sv
// Purpose: host controller model on the far side of the keyboard link
// Assumes: lines resolved in the bench with pull-ups
// Notes: link clock 80 ns, moved off the bench clock edges by 1 ns
`timescale 1ns/1ns
module kb_host_model (
	input wire logic i_line_clk,
	input wire logic i_line_data,
	output logic o_clk_oe,
	output logic o_data_oe
);
	localparam int HALF_NS = 40;

	initial begin
		o_clk_oe = 1'b0;
		o_data_oe = 1'b0;
	end

	// data low with clock high, then eleven host clocks
	task automatic send(input logic [7:0] b, input logic bad_par);
		logic [10:0] f;
		int i;
		begin
			f = {1'b1, ~^b ^ bad_par, b, 1'b0};
			#1;
			o_data_oe = 1'b1;
			#HALF_NS;
			for (i = 0; i < 11; i++) begin
				o_data_oe = ~f[i];
				#(HALF_NS / 2);
				o_clk_oe = 1'b1;
				#HALF_NS;
				o_clk_oe = 1'b0;
				#(HALF_NS / 2);
			end
			o_data_oe = 1'b0;
		end
	endtask

	// sample on falling clock, check start, parity, stop
	task automatic recv(output logic [7:0] b, output logic ok);
		logic [10:0] f;
		int i;
		begin
			for (i = 0; i < 11; i++) begin
				@(negedge i_line_clk);
				f[i] = i_line_data;
			end
			b = f[8:1];
			ok = !f[0] && f[10] && (^f[9:1]);
			// Frame ends only when the keyboard lets the clock go
			@(posedge i_line_clk);
		end
	endtask

	// pull clock low inside a released half before parity
	task automatic abort_after(input int n);
		int i;
		begin
			for (i = 0; i < n; i++) begin
				@(negedge i_line_clk);
			end
			@(posedge i_line_clk);
			#31;
			o_clk_oe = 1'b1;
		end
	endtask

	task automatic inhibit(input logic v);
		o_clk_oe = v;
	endtask
endmodule

// ### test/keyboard_serial_link_commands_bench.sv
// Purpose: self-checking bench for the keyboard link device
// Assumes: short half-bit and reset-pulse counts
// Notes: command rows hold the byte sent and up to three answers
`timescale 1ns/1ns
module keyboard_serial_link_commands_bench;
	logic clk;
	logic nrst;
	logic [3:0] addr;
	logic rd;
	logic wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic waitreq;
	logic kb_clk_oe;
	logic kb_data_oe;
	logic host_clk_oe;
	logic host_data_oe;
	logic scan_active;
	logic [2:0] leds;
	logic scan_set2;
	logic [9:0] delay_ms;
	logic [7:0] period;
	logic kb_clk_out;
	logic kb_data_out;
	logic flush;
	logic [3:0] be;
	logic [31:0] d;
	logic [7:0] b;
	logic ok;
	int error_cnt = 0;
	int check_count = 0;
	int flush_cnt = 0;
	int r;
	wire line_clk = !(kb_clk_oe || host_clk_oe);
	wire line_data = !(kb_data_oe || host_data_oe);
	// Command byte, answer count, answers
	logic [39:0] rows [17] = '{
		40'hEE_01EE_0000, 40'hED_01FA_0000, 40'h05_01FA_0000, 40'hF0_01FA_0000,
		40'h02_02FA_0200, 40'hF0_01FA_0000, 40'h00_02FA_0200, 40'hF2_03FA_5A3C,
		40'hF5_01FA_0000, 40'hF6_01FA_0000, 40'hF3_01FA_0000, 40'h7F_01FA_0000,
		40'hED_01FA_0000, 40'hEE_01EE_0000, 40'h11_01FE_0000, 40'hFE_01EE_0000,
		40'hF4_01FA_0000};

	kb_link_device #(.TX_HALF_CYCLES(20), .RST_PULSE_CYCLES(100)) u_kb_link_device (
		.i_clk(clk), .i_nrst(nrst), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_kbd_clk(line_clk),
		.o_kbd_clk_out(kb_clk_out), .o_kbd_clk_oe(kb_clk_oe), .i_kbd_data(line_data),
		.o_kbd_data_out(kb_data_out), .o_kbd_data_oe(kb_data_oe),
		.o_scan_active(scan_active), .o_flush(flush), .o_leds(leds), .o_scan_set2(scan_set2),
		.o_typematic_delay_ms(delay_ms), .o_typematic_period(period));

	kb_host_model u_kb_host_model (
		.i_line_clk(line_clk), .i_line_data(line_data),
		.o_clk_oe(host_clk_oe), .o_data_oe(host_data_oe));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Flush is a one-cycle pulse, so count it as it goes by
	always @(posedge clk) begin
		if (flush === 1'b1) begin
			flush_cnt <= flush_cnt + 1;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("mismatches %0d comparisons %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Hold the request until waitrequest is seen low at a rising edge
	task automatic av_xfer(input logic [3:0] a, input logic w, input logic [31:0] wd);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= wd;
			rd <= !w;
			wr <= w;
			// Values read here are those sampled at this edge
			do begin
				@(posedge clk);
			end while (waitreq !== 1'b0);
			d = rdata;
			rd <= 1'b0;
			wr <= 1'b0;
		end
	endtask

	task automatic expect_byte(input logic [7:0] e);
		u_kb_host_model.recv(b, ok);
		check(32'(ok), 32'h1);
		check(32'(b), 32'(e));
	endtask

	task automatic xfer(input logic [39:0] row);
		int k;
		begin
			u_kb_host_model.send(row[39:32], 1'b0);
			for (k = 0; k < row[31:24]; k++) begin
				expect_byte(row[23 - 8 * k -: 8]);
			end
		end
	endtask

	initial begin
		#300000;
		error_cnt++;
		summarize();
	end

	initial begin
		nrst = 1'b0;
		addr = 4'h0;
		rd = 1'b0;
		wr = 1'b0;
		wdata = 32'h0000_0000;
		be = 4'hF;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		#1;
		check({kb_clk_oe, kb_data_oe}, 32'h0);
		check({kb_clk_out, kb_data_out}, 32'h0);
		check({leds, scan_set2, delay_ms, period}, {4'h0, 10'd500, 8'h16});
		av_xfer(4'h4, 1'b0, 32'h0);
		check(32'(d[0]), 32'h1);
		av_xfer(4'h0, 1'b1, 32'h0000_0001);
		expect_byte(8'hAA);
		for (r = 0; r < 17; r++) begin
			xfer(rows[r]);
		end
		#1;
		check(32'(leds), 32'h5);
		check(32'(scan_set2), 32'h1);
		check(32'(delay_ms), 32'd1000);
		check(32'(period), 32'd120);
		check(32'(scan_active), 32'h1);
		check(flush_cnt, 32'd3);
		av_xfer(4'h8, 1'b1, 32'h0000_001C);
		expect_byte(8'h1C);
		// Key write without its low byte lane must not queue a byte
		be <= 4'h0;
		av_xfer(4'h8, 1'b1, 32'h0000_0033);
		be <= 4'hF;
		av_xfer(4'h4, 1'b0, 32'h0);
		check(32'(d[5]), 32'h0);
		u_kb_host_model.send(8'hEE, 1'b1);
		expect_byte(8'hFE);
		u_kb_host_model.send(8'hEE, 1'b0);
		u_kb_host_model.inhibit(1'b1);
		#2000;
		check({kb_clk_oe, kb_data_oe}, 32'h0);
		u_kb_host_model.inhibit(1'b0);
		expect_byte(8'hEE);
		u_kb_host_model.send(8'hEE, 1'b0);
		u_kb_host_model.abort_after(3);
		#1000;
		check({kb_clk_oe, kb_data_oe}, 32'h0);
		u_kb_host_model.inhibit(1'b0);
		expect_byte(8'hEE);
		u_kb_host_model.send(8'hFF, 1'b0);
		expect_byte(8'hFA);
		#2000;
		av_xfer(4'h4, 1'b0, 32'h0);
		check(32'(d[0]), 32'h1);
		av_xfer(4'h2, 1'b0, 32'h0);
		check(d, 32'h0000_0000);
		summarize();
	end
endmodule
